// >>> common/vtpg_defines.vh
// Constants for the video test pattern generator register map and timing.
// What this block does
// - Generator enable bit 0 of control selects pattern video, else incoming video passes through.
// - Colour bar bit 2 gives white,yellow,cyan,green,magenta,red,blue,black bars.
// - Checker scale bit makes checker squares 8x8 and alternating blocks 8x16, else 1x1 and 1x2.
// - Custom checker bit alternates custom colour with black, else white with black.
// - Reduced depth bit gives 18-bit colour, 64 ramp levels, six MSBs used.
// - Reduced depth bit clear gives 24-bit colour with 256 ramp levels.
// - Internal timing uses external pixel clock if source bit set, else divider.
// - Timing select set makes own timing from programmed sizes, syncs, porches.
// - Timing select clear follows external pixel clock, enable and syncs.
// - Invert bit inverts every generated colour, else colours pass unchanged.
// - Auto-scroll advances to next pattern each frame-time count of frames.
// - In independent mode configuration applies only to the selected port.
// - Indirect data writes and reads the location the indirect address selects.
// - Auto-scroll makes the block ignore the fixed pattern select field.
`ifndef VTPG_DEFINES_VH
`define VTPG_DEFINES_VH
`define VTPG_IDX_CONTROL 8'h64
`define VTPG_IDX_CONFIG  8'h65
`define VTPG_IDX_IADDR   8'h66
`define VTPG_IDX_IDATA   8'h67
`define VTPG_IDX_ROUTING 8'h70
`define VTPG_BADDR(i)    ({2'b00, (i), 2'b00})
`define VTPG_CONTROL_RST 8'h10
`define VTPG_CONFIG_RST  8'h00
`define VTPG_ZERO8       8'h00
`define VTPG_CTL_MASK    8'hf5
`define VTPG_CTL_EN      0
`define VTPG_CTL_BARS    2
`define VTPG_CTL_SEL     7:4
`define VTPG_CFG_SCALE   6
`define VTPG_CFG_CUST    5
`define VTPG_CFG_D18     4
`define VTPG_CFG_EXTCLK  3
`define VTPG_CFG_TSEL    2
`define VTPG_CFG_INV     1
`define VTPG_CFG_ASCRL   0
`define VTPG_RT_INDEP    0
`define VTPG_RT_PORT     1
`define VTPG_IND_DEPTH   32
`define VTPG_IND_USED    8'h11
`define VTPG_IA_TW_LO    0
`define VTPG_IA_TW_HI    1
`define VTPG_IA_TH_LO    2
`define VTPG_IA_TH_HI    3
`define VTPG_IA_AW_LO    4
`define VTPG_IA_AW_HI    5
`define VTPG_IA_AH_LO    6
`define VTPG_IA_AH_HI    7
`define VTPG_IA_HSW      8
`define VTPG_IA_VSW      9
`define VTPG_IA_HBP      10
`define VTPG_IA_VBP      11
`define VTPG_IA_SYNC     12
`define VTPG_IA_FTIME    13
`define VTPG_IA_RED      14
`define VTPG_IA_GREEN    15
`define VTPG_IA_BLUE     16
`define VTPG_DIV_LAST    2'd1
`define VTPG_SYNC_W      28
`define VTPG_LEVELS_24   13'd256
`define VTPG_LEVELS_18   13'd64
`define VTPG_BARS        13'd8
`define VTPG_MASK_18     24'hfcfcfc
`endif

// >>> dv/tb_vtpg_top.sv
// Self-checking bench for the two-port video test pattern generator.
`timescale 1ns/1ps
module tb_vtpg_top;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, ext_pclk, ext_de, ext_hs, ext_vs;
   wire  [23:0] ext_rgb;
   wire  [47:0] out_rgb;
   wire  [1:0]  out_de, out_hs, out_vs;
   int          mismatches, total_checks;
   vtpg_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_pclk(ext_pclk), .ext_de(ext_de),
      .ext_hs(ext_hs), .ext_vs(ext_vs), .ext_rgb(ext_rgb),
      .out_rgb(out_rgb), .out_de(out_de), .out_hs(out_hs),
      .out_vs(out_vs));
   vtpg_video_src u_src (.pclk(pclk), .presetn(presetn),
      .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs),
      .ext_vs(ext_vs), .ext_rgb(ext_rgb));
   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      check("pready", {31'h0, pready}, 32'h1);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check("read", rd, {24'h0, e});
   endtask
   task automatic t_regs;
      rdc(12'h190, 8'h10);
      rdc(12'h194, 8'h00);
      rdc(12'h198, 8'h00);
      apb(1'b1, 12'h1c0, 8'h01);
      apb(1'b1, 12'h194, 8'h02);
      apb(1'b1, 12'h1c0, 8'h03);
      rdc(12'h194, 8'h00);
      apb(1'b1, 12'h1c0, 8'h01);
      rdc(12'h194, 8'h02);
      apb(1'b1, 12'h1c0, 8'h00);
      apb(1'b1, 12'h190, 8'hff);
      rdc(12'h190, 8'hf5);
      apb(1'b1, 12'h194, 8'hff);
      rdc(12'h194, 8'hff);
      apb(1'b0, 12'h004, 8'h00);
      check("unmapped err", {31'h0, err}, 32'h1);
      apb(1'b1, 12'h191, 8'h55);
      check("misaligned err", {31'h0, err}, 32'h1);
      apb(1'b1, 12'h198, 8'h05);
      apb(1'b1, 12'h19c, 8'ha5);
      rdc(12'h19c, 8'ha5);
      apb(1'b1, 12'h198, 8'h11);
      apb(1'b1, 12'h19c, 8'h77);
      rdc(12'h19c, 8'h00);
      $display("test registers done");
   endtask
   task automatic wait_de(input logic vs, input logic lvl);
      int n;
      n = 0;
      while ((vs ? out_vs[0] : out_de[0]) !== lvl && n < 3000) begin
         @(posedge pclk);
         n++;
      end
   endtask
   // Small frame; custom colour 123456, frame time of one.
   // The first two pixels of line 0 are judged, so x and y are known.
   task automatic t_video;
      logic [7:0]  ia[13] = '{0, 2, 4, 5, 6, 8, 9, 10, 11, 13, 14, 15, 16};
      logic [7:0]  iv[13] = '{16, 8, 8, 0, 4, 1, 1, 2, 1, 1, 8'h12, 8'h34,
                              8'h56};
      logic [7:0]  cfg[9] = '{8'h04, 8'h06, 8'h14, 8'h00, 8'h04, 8'h00,
                              8'h24, 8'h44, 8'h04};
      logic [7:0]  ctl[9] = '{8'he1, 8'he1, 8'he1, 8'he1, 8'he5, 8'he0,
                              8'h01, 8'h01, 8'hf1};
      logic [23:0] pix[9] = '{24'h123456, 24'hedcba9, 24'h103454,
                              24'h123456, 24'hffffff, 24'h0a0b0c,
                              24'h000000, 24'h000000, 24'h000000};
      logic [23:0] nxt[9] = '{24'h123456, 24'hedcba9, 24'h103454,
                              24'h123456, 24'hffff00, 24'h0a0b0c,
                              24'h123456, 24'h000000, 24'hffffff};
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, 12'h198, ia[i]);
         apb(1'b1, 12'h19c, iv[i]);
      end
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, 12'h194, cfg[i]);
         apb(1'b1, 12'h190, ctl[i]);
         repeat (2500) @(posedge pclk);
         wait_de(1'b1, 1'b1);
         wait_de(1'b0, 1'b0);
         wait_de(1'b0, 1'b1);
         check("pix0", out_rgb[23:0], pix[i]);
         // Two cycles on, the internal divider has shown pixel x=1.
         repeat (2) @(posedge pclk);
         check("pix1", out_rgb[23:0], nxt[i]);
      end
      $display("test video done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Free-running 40 MHz bus clock.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Cuts a hang well beyond the expected run of about 25000 cycles.
   initial begin
      #2000000;
      mismatches++;
      tally_and_finish;
   end
   // Reset for two cycles, then the scenarios in order.
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      mismatches = 0;
      total_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_video;
      tally_and_finish;
   end
endmodule
bind vtpg_top vtpg_sva u_sva (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .out_rgb(out_rgb), .out_de(out_de));

// >>> dv/vtpg_sva.sv
// Port checker for the pattern generator register bus and video reset.
`timescale 1ns/1ps
module vtpg_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [47:0] out_rgb,
   input wire logic [1:0]  out_de
);
   // Everything here lives on the one bus clock.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_one_cycle_a: assert property ((pready && clk_en) |=> !pready)
      else $error("pready stood longer than one cycle");
   rdy_after_access_a: assert property
      ((clk_en && psel && penable && !$past(penable)) |=> pready)
      else $error("pready missing after first access cycle");
   rdy_in_access_a: assert property (pready |-> (psel && penable))
      else $error("pready outside an access phase");
   err_with_rdy_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   misalign_err_a: assert property
      ((pready && paddr[1:0] != 2'b00) |-> pslverr)
      else $error("misaligned access not refused");
   refused_zero_a: assert property
      ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
      else $error("refused read returned data");
   ctl_reserved_a: assert property
      ((pready && !pwrite && paddr == 12'h190) |-> !prdata[3] && !prdata[1])
      else $error("reserved control bits read as one");
   reset_idle_a: assert property
      ($rose(presetn) |-> out_de == 2'b00 && out_rgb == 48'h0)
      else $error("video outputs active after reset");
   cover property (pready && pslverr);
   cover property (pready && !pwrite && paddr == 12'h19c);
   cover property (out_de[0]);
endmodule

// >>> dv/vtpg_video_src.sv
// Incoming video source with a slow free-running pixel clock.
`timescale 1ns/1ps
module vtpg_video_src #(parameter logic [23:0] PIX = 24'h0a0b0c) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   output wire logic        ext_pclk,
   output wire logic        ext_de,
   output wire logic        ext_hs,
   output wire logic        ext_vs,
   output wire logic [23:0] ext_rgb
);
   logic [9:0] cnt_reg;
   wire  [9:0] ph = cnt_reg - 10'h004;
   // Pixel clock at pclk/8, far below the synchroniser limit.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cnt_reg <= 10'h000;
      else
         cnt_reg <= cnt_reg + 10'h001;
   end
   // Pins move on the rising pixel edge so the falling edge sees them
   // stable; 16 pixels a line, 8 lines a frame, 8x4 active.
   assign ext_pclk = cnt_reg[2];
   assign ext_de   = !ph[6] && !ph[9];
   assign ext_hs   = ph[6:4] == 3'h6;
   assign ext_vs   = ph[9:7] == 3'h7;
   assign ext_rgb  = ext_de ? PIX : ~PIX;
endmodule

// >>> hdl/vtpg_timing.v
// Pixel timing core: own or followed timing, pixel position, ramp levels.
`timescale 1ns/1ps
`include "vtpg_defines.vh"
module vtpg_timing (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        tick,
   input  wire        tsel,
   input  wire        d18,
   input  wire        ext_de,
   input  wire        ext_hs,
   input  wire        ext_vs,
   input  wire [11:0] total_w,
   input  wire [11:0] total_h,
   input  wire [11:0] active_w,
   input  wire [11:0] active_h,
   input  wire [7:0]  hsync_w,
   input  wire [7:0]  vsync_w,
   input  wire [7:0]  hback,
   input  wire [7:0]  vback,
   input  wire [1:0]  sync_pol,
   output wire        cur_de,
   output wire        cur_hs,
   output wire        cur_vs,
   output wire [11:0] cur_x,
   output wire [11:0] cur_y,
   output wire        frame_start,
   output reg  [7:0]  hlvl_reg,
   output reg  [7:0]  vlvl_reg,
   output reg  [2:0]  bar_reg
);
   reg  [11:0] h_reg, v_reg, x_reg, y_reg;
   reg  [12:0] hacc_reg, vacc_reg, bacc_reg;
   reg         de_d_reg, vs_d_reg;
   wire [11:0] h_last = total_w - 12'h001;
   wire [11:0] v_last = total_h - 12'h001;
   wire [11:0] hs_stop = total_w - {4'h0, hback};
   wire [11:0] vs_stop = total_h - {4'h0, vback};
   wire [11:0] hs_start = hs_stop - {4'h0, hsync_w};
   wire [11:0] vs_start = vs_stop - {4'h0, vsync_w};
   wire [12:0] levels = d18 ? `VTPG_LEVELS_18 : `VTPG_LEVELS_24;
   wire [12:0] hsum = hacc_reg + levels;
   wire [12:0] bsum = bacc_reg + `VTPG_BARS;
   wire [12:0] vsum = vacc_reg + levels;
   wire        int_de = (h_reg < active_w) && (v_reg < active_h);
   wire        int_hs = (h_reg >= hs_start) && (h_reg < hs_stop);
   wire        int_vs = (v_reg >= vs_start) && (v_reg < vs_stop);
   wire        line_end = tick && de_d_reg && !cur_de;

   // Own timing from the programmed frame, else followed pins.
   assign cur_de = tsel ? int_de : ext_de;
   assign cur_hs = tsel ? (int_hs ^ sync_pol[0]) : ext_hs;
   assign cur_vs = tsel ? (int_vs ^ sync_pol[1]) : ext_vs;
   assign cur_x = tsel ? h_reg : x_reg;
   assign cur_y = tsel ? v_reg : y_reg;
   assign frame_start = tick && (tsel ? (h_reg == h_last && v_reg == v_last)
                                      : (ext_vs && !vs_d_reg));

   // Raster counters; the followed position restarts on enable and sync.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_reg <= 12'h000;
         v_reg <= 12'h000;
         x_reg <= 12'h000;
         y_reg <= 12'h000;
         de_d_reg <= 1'b0;
         vs_d_reg <= 1'b0;
      end else if (clk_en && tick) begin
         de_d_reg <= cur_de;
         vs_d_reg <= ext_vs;
         if (h_reg >= h_last) begin
            h_reg <= 12'h000;
            v_reg <= (v_reg >= v_last) ? 12'h000 : v_reg + 12'h001;
         end else begin
            h_reg <= h_reg + 12'h001;
         end
         x_reg <= ext_de ? x_reg + 12'h001 : 12'h000;
         if (ext_vs && !vs_d_reg) begin
            y_reg <= 12'h000;
         end else if (de_d_reg && !ext_de) begin
            y_reg <= y_reg + 12'h001;
         end
      end
   end

   // Ramp and bar steppers spread the levels evenly over the active area.
   // They divide by repeated subtraction, so no divider is needed.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hacc_reg <= 13'h0000;
         bacc_reg <= 13'h0000;
         vacc_reg <= 13'h0000;
         hlvl_reg <= 8'h00;
         vlvl_reg <= 8'h00;
         bar_reg <= 3'h0;
      end else if (clk_en && tick) begin
         if (!cur_de) begin
            hacc_reg <= 13'h0000;
            bacc_reg <= 13'h0000;
            hlvl_reg <= 8'h00;
            bar_reg <= 3'h0;
         end else begin
            if (hsum >= {1'b0, active_w}) begin
               hacc_reg <= hsum - {1'b0, active_w};
               hlvl_reg <= hlvl_reg + 8'h01;
            end else begin
               hacc_reg <= hsum;
            end
            if (bsum >= {1'b0, active_w}) begin
               bacc_reg <= bsum - {1'b0, active_w};
               bar_reg <= bar_reg + 3'h1;
            end else begin
               bacc_reg <= bsum;
            end
         end
         if (frame_start) begin
            vacc_reg <= 13'h0000;
            vlvl_reg <= 8'h00;
         end else if (line_end) begin
            if (vsum >= {1'b0, active_h}) begin
               vacc_reg <= vsum - {1'b0, active_h};
               vlvl_reg <= vlvl_reg + 8'h01;
            end else begin
               vacc_reg <= vsum;
            end
         end
      end
   end
endmodule

// >>> hdl/vtpg_top.v
// Two-port video test pattern generator with its APB register file.
`timescale 1ns/1ps
`include "vtpg_defines.vh"
module vtpg_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        ext_pclk,
   input  wire        ext_de,
   input  wire        ext_hs,
   input  wire        ext_vs,
   input  wire [23:0] ext_rgb,
   output reg  [47:0] out_rgb,
   output reg  [1:0]  out_de,
   output reg  [1:0]  out_hs,
   output reg  [1:0]  out_vs
);
   localparam [2:0] SEL_NONE = 3'd0;
   localparam [2:0] SEL_CTL  = 3'd1;
   localparam [2:0] SEL_CFG  = 3'd2;
   localparam [2:0] SEL_IA   = 3'd3;
   localparam [2:0] SEL_ID   = 3'd4;
   localparam [2:0] SEL_RT   = 3'd5;

   reg  [`VTPG_SYNC_W-1:0] sync1_reg, sync2_reg;
   reg         pclk_d_reg;
   reg  [1:0]  div_reg;
   reg         tick_int;
   reg  [7:0]  route_reg;
   wire [15:0] ctl_all, cfg_all, ia_all, id_all;
   wire [7:0]  pat_all;
   wire        indep = route_reg[`VTPG_RT_INDEP];
   wire        rport = indep & route_reg[`VTPG_RT_PORT];
   wire        access = psel && penable;
   wire        commit = access && pready;
   wire [2:0]  hit = reg_decode(paddr);
   wire        s_pclk = sync2_reg[27];
   wire        s_vs = sync2_reg[26];
   wire        s_hs = sync2_reg[25];
   wire        s_de = sync2_reg[24];
   wire [23:0] s_rgb = sync2_reg[23:0];
   wire        tick_ext = pclk_d_reg && !s_pclk;
   reg  [7:0]  rd_val;

   // Maps a byte address onto a register; misaligned words miss.
   function [2:0] reg_decode;
      input [11:0] a;
      begin
         if (a[1:0] != 2'b00) begin
            reg_decode = SEL_NONE;
         end else begin
            case (a)
               `VTPG_BADDR(`VTPG_IDX_CONTROL): reg_decode = SEL_CTL;
               `VTPG_BADDR(`VTPG_IDX_CONFIG):  reg_decode = SEL_CFG;
               `VTPG_BADDR(`VTPG_IDX_IADDR):   reg_decode = SEL_IA;
               `VTPG_BADDR(`VTPG_IDX_IDATA):   reg_decode = SEL_ID;
               `VTPG_BADDR(`VTPG_IDX_ROUTING): reg_decode = SEL_RT;
               default: reg_decode = SEL_NONE;
            endcase
         end
      end
   endfunction

   // Expands a red-green-blue bit triple to a colour at one level.
   function [23:0] tint;
      input [2:0] m;
      input [7:0] v;
      begin
         tint = {m[2] ? v : 8'h00, m[1] ? v : 8'h00, m[0] ? v : 8'h00};
      end
   endfunction

   // Pixel colour for a pattern code before inversion and depth cut.
   function [23:0] pixel;
      input [3:0]  code;
      input        chk;
      input        alt;
      input        cust_chk;
      input [7:0]  hl;
      input [7:0]  vl;
      input [23:0] cust;
      reg   [2:0]  rm;
      begin
         rm = (code[1:0] == 2'd0) ? 3'b111 : (3'b100 >> (code[1:0] - 2'd1));
         case (code)
            4'd0: pixel = chk ? (cust_chk ? cust : tint(3'b111, 8'hff))
                              : 24'h000000;
            4'd1: pixel = tint(3'b111, 8'hff);
            4'd2: pixel = 24'h000000;
            4'd3: pixel = tint(3'b100, 8'hff);
            4'd4: pixel = tint(3'b010, 8'hff);
            4'd5: pixel = tint(3'b001, 8'hff);
            4'd6, 4'd7, 4'd8, 4'd9: pixel = tint(3'b111 & {3{1'b1}} &
                                                 (code == 4'd6 ? 3'b111 :
                                                  3'b100 >> (code - 4'd7)),
                                                 hl);
            4'd10, 4'd11, 4'd12, 4'd13: pixel = tint(
                                  code == 4'd10 ? 3'b111 :
                                  3'b100 >> (code - 4'd11), vl);
            4'd14: pixel = cust;
            4'd15: pixel = alt ? tint(3'b111, 8'hff) : 24'h000000;
            default: pixel = tint(rm, 8'h00);
         endcase
      end
   endfunction

   // Two-flop synchronisers for every pin that crosses in from outside.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= {`VTPG_SYNC_W{1'b0}};
         sync2_reg <= {`VTPG_SYNC_W{1'b0}};
         pclk_d_reg <= 1'b0;
         div_reg <= 2'd0;
         tick_int <= 1'b0;
      end else if (clk_en) begin
         sync1_reg <= {ext_pclk, ext_vs, ext_hs, ext_de, ext_rgb};
         sync2_reg <= sync1_reg;
         pclk_d_reg <= s_pclk;
         div_reg <= (div_reg == `VTPG_DIV_LAST) ? 2'd0 : div_reg + 2'd1;
         tick_int <= (div_reg == `VTPG_DIV_LAST);
      end
   end

   // APB slave: one wait state, then the write lands or read data shows.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         route_reg <= `VTPG_ZERO8;
      end else if (clk_en) begin
         pready <= access && !pready;
         // The error flag stands only with pready, never beyond it.
         pslverr <= access && !pready && (hit == SEL_NONE);
         if (access && !pready) begin
            prdata <= {24'h000000, rd_val};
         end
         if (commit && pwrite && hit == SEL_RT) begin
            route_reg <= {6'h00, pwdata[`VTPG_RT_PORT:`VTPG_RT_INDEP]};
         end
      end
   end

   // Read mux; the selected port's copy answers in independent mode.
   always @* begin
      case (hit)
         SEL_CTL: rd_val = ctl_all[rport*8 +: 8] & `VTPG_CTL_MASK;
         SEL_CFG: rd_val = cfg_all[rport*8 +: 8];
         SEL_IA:  rd_val = ia_all[rport*8 +: 8];
         SEL_ID:  rd_val = id_all[rport*8 +: 8];
         SEL_RT:  rd_val = {pat_all[rport*4 +: 4], 2'b00,
                            route_reg[`VTPG_RT_PORT:`VTPG_RT_INDEP]};
         default: rd_val = `VTPG_ZERO8;
      endcase
   end

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         reg  [7:0]  ctl_reg, cfg_reg, ia_reg;
         reg  [7:0]  mem [0:`VTPG_IND_DEPTH-1];
         reg  [7:0]  lctl_reg, lcfg_reg;
         reg  [23:0] lcust_reg;
         reg  [3:0]  pat_reg;
         reg  [7:0]  fcnt_reg;
         wire        wr_mine = commit && pwrite &&
                               (!indep || route_reg[`VTPG_RT_PORT] == p);
         wire [23:0] cust = {mem[`VTPG_IA_RED], mem[`VTPG_IA_GREEN],
                             mem[`VTPG_IA_BLUE]};
         wire        en = ctl_reg[`VTPG_CTL_EN];
         wire        tsel = lcfg_reg[`VTPG_CFG_TSEL];
         wire        tick = (tsel && !lcfg_reg[`VTPG_CFG_EXTCLK]) ?
                            tick_int : tick_ext;
         wire        de, hs, vs, fstart;
         wire [11:0] x, y;
         wire [7:0]  hl, vl;
         wire [2:0]  bar;
         wire        sc = lcfg_reg[`VTPG_CFG_SCALE];
         wire        chk = sc ? (x[3] ^ y[3]) : (x[0] ^ y[0]);
         wire        alt = sc ? (x[3] ^ y[4]) : (x[0] ^ y[1]);
         wire        d18 = lcfg_reg[`VTPG_CFG_D18];
         wire [7:0]  hl8 = d18 ? {hl[5:0], 2'b00} : hl;
         wire [7:0]  vl8 = d18 ? {vl[5:0], 2'b00} : vl;
         wire [8:0]  fnext = {1'b0, fcnt_reg} + 9'h001;
         reg  [23:0] pix;
         integer     i;

         assign ctl_all[p*8 +: 8] = ctl_reg;
         assign cfg_all[p*8 +: 8] = cfg_reg;
         assign ia_all[p*8 +: 8] = ia_reg;
         assign pat_all[p*4 +: 4] = pat_reg;
         assign id_all[p*8 +: 8] = (ia_reg < `VTPG_IND_USED) ?
                                   mem[ia_reg[4:0]] : `VTPG_ZERO8;

         // Per-port registers; a shared write reaches both copies.
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctl_reg <= `VTPG_CONTROL_RST;
               cfg_reg <= `VTPG_CONFIG_RST;
               ia_reg <= `VTPG_ZERO8;
               for (i = 0; i < `VTPG_IND_DEPTH; i = i + 1) begin
                  mem[i] <= `VTPG_ZERO8;
               end
            end else if (clk_en && wr_mine) begin
               if (hit == SEL_CTL) begin
                  ctl_reg <= pwdata[7:0] & `VTPG_CTL_MASK;
               end
               if (hit == SEL_CFG) begin
                  cfg_reg <= pwdata[7:0];
               end
               if (hit == SEL_IA) begin
                  ia_reg <= pwdata[7:0];
               end
               if (hit == SEL_ID && ia_reg < `VTPG_IND_USED) begin
                  mem[ia_reg[4:0]] <= pwdata[7:0];
               end
            end
         end

         // Settings are taken at frame start so pattern, colour and config never change mid-frame.
         // While idle they track the registers, so enabling is prompt.
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lctl_reg <= `VTPG_CONTROL_RST;
               lcfg_reg <= `VTPG_CONFIG_RST;
               lcust_reg <= 24'h000000;
               pat_reg <= 4'h0;
               fcnt_reg <= 8'h00;
            end else if (clk_en && (fstart || !en)) begin
               lctl_reg <= ctl_reg;
               lcfg_reg <= cfg_reg;
               lcust_reg <= cust;
               if (!en || !cfg_reg[`VTPG_CFG_ASCRL]) begin
                  pat_reg <= ctl_reg[`VTPG_CTL_SEL];
                  fcnt_reg <= 8'h00;
               end else if (fnext >= {1'b0, mem[`VTPG_IA_FTIME]}) begin
                  pat_reg <= pat_reg + 4'h1;
                  fcnt_reg <= 8'h00;
               end else begin
                  fcnt_reg <= fnext[7:0];
               end
            end
         end

         // Colour path: bars, pattern, inversion, then depth cut.
         always @* begin
            if (lctl_reg[`VTPG_CTL_BARS]) begin
               pix = tint({~bar[1], ~bar[2], ~bar[0]}, 8'hff);
            end else begin
               pix = pixel(pat_reg, chk, alt, lcfg_reg[`VTPG_CFG_CUST],
                           hl8, vl8, lcust_reg);
            end
            if (lcfg_reg[`VTPG_CFG_INV]) begin
               pix = ~pix;
            end
            if (d18) begin
               pix = pix & `VTPG_MASK_18;
            end
            if (!de) begin
               pix = 24'h000000;
            end
         end

         // Output stage: pattern replaces the incoming video when enabled.
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               out_rgb[p*24 +: 24] <= 24'h000000;
               out_de[p] <= 1'b0;
               out_hs[p] <= 1'b0;
               out_vs[p] <= 1'b0;
            end else if (clk_en && (en ? tick : tick_ext)) begin
               out_rgb[p*24 +: 24] <= en ? pix : s_rgb;
               out_de[p] <= en ? de : s_de;
               out_hs[p] <= en ? hs : s_hs;
               out_vs[p] <= en ? vs : s_vs;
            end
         end

         vtpg_timing u_timing (
            .pclk        (pclk),
            .presetn     (presetn),
            .clk_en      (clk_en),
            .tick        (tick),
            .tsel        (tsel),
            .d18         (d18),
            .ext_de      (s_de),
            .ext_hs      (s_hs),
            .ext_vs      (s_vs),
            .total_w     ({mem[`VTPG_IA_TW_HI][3:0], mem[`VTPG_IA_TW_LO]}),
            .total_h     ({mem[`VTPG_IA_TH_HI][3:0], mem[`VTPG_IA_TH_LO]}),
            .active_w    ({mem[`VTPG_IA_AW_HI][3:0], mem[`VTPG_IA_AW_LO]}),
            .active_h    ({mem[`VTPG_IA_AH_HI][3:0], mem[`VTPG_IA_AH_LO]}),
            .hsync_w     (mem[`VTPG_IA_HSW]),
            .vsync_w     (mem[`VTPG_IA_VSW]),
            .hback       (mem[`VTPG_IA_HBP]),
            .vback       (mem[`VTPG_IA_VBP]),
            .sync_pol    (mem[`VTPG_IA_SYNC][1:0]),
            .cur_de      (de),
            .cur_hs      (hs),
            .cur_vs      (vs),
            .cur_x       (x),
            .cur_y       (y),
            .frame_start (fstart),
            .hlvl_reg    (hl),
            .vlvl_reg    (vl),
            .bar_reg     (bar)
         );
      end
   endgenerate
endmodule
